/* design/head_ctrl_consts.svh */
// Constants for the head select and write control block
`ifndef HEAD_CTRL_CONSTS_SVH
`define HEAD_CTRL_CONSTS_SVH
`define CLK_MHZ 50
`define SQUELCH_DELAY_NS 2000
`define SQUELCH_DELAY_CYC ((`SQUELCH_DELAY_NS * `CLK_MHZ) / 1000)
`define XCHK_BYTES 12
`define BYTE_NS 800
`define XCHK_DELAY_CYC ((`XCHK_BYTES * `BYTE_NS * `CLK_MHZ) / 1000)
`define CNT_W 10
`define MV_CHIPS 5
`define FX_CHIPS 15
`define IW_20MA 2'h0
`define IW_25MA 2'h1
`define IW_40MA 2'h2
`define IW_45MA 2'h3
`define ERR_RST 5'h00
`define SYNC_RST 12'h500
`endif

/* design/head_ctrl_pkg.sv */
// Types for the head select and write control block
package head_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WRITE,
        ST_RECOVER
    } wr_state_t;
    typedef struct packed {
        logic head_short;
        logic write_on_read;
        logic transition;
        logic delta_iw;
        logic multi_head;
    } err_flags_t;
    typedef struct packed {
        logic fixed_mode;
        logic [1:0] fixed_head_range_bits;
        logic [4:0] head_address_bits;
    } head_sel_t;
endpackage

/* design/disk_head_select_write_ctrl.sv */
// Head select, write gating, read switching and error checks of the drive
`timescale 1ns/1ps
`default_nettype none
`include "head_ctrl_consts.svh"
module disk_head_select_write_ctrl (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Controller side
    input wire head_ctrl_pkg::head_sel_t head_sel_in,
    input wire logic write_gate_select_n_in,
    input wire logic read_only_flag_in,
    input wire logic mfm_write_data_in,
    input wire logic read_tag3_in,
    input wire logic read_bus1_in,
    input wire logic am_read_cmd_in,
    input wire logic variable_sector_in,
    // Enclosure sense lines
    input wire logic fixed_block_present_n_in,
    input wire logic unsafe_fixed_in,
    input wire logic unsafe_movable_in,
    input wire logic delta_active_in,
    input wire logic supply_overload_in,
    input wire logic wsel_overcurrent_in,
    input wire logic write_current_sense_in,
    input wire logic movable_head_data_pair_in,
    input wire logic fixed_head_data_pair_in,
    // Head selects
    output logic [`MV_CHIPS-1:0] movable_chip_select_n_out,
    output logic [`FX_CHIPS-1:0] fixed_chip_select_n_out,
    output logic [1:0] head_core_select_out,
    output logic [2:0] fixed_head_range_lines_out,
    // Write drive
    output logic write_select_movable_out,
    output logic write_select_fixed_out,
    output logic write_mode_movable_out,
    output logic write_mode_fixed_out,
    output logic write_current_en_out,
    output logic [1:0] write_current_level_out,
    output logic main_current_select_out,
    output logic delta_current_gate1_out,
    output logic delta_current_gate2_out,
    // Head data pairs, each with its enable
    output logic [1:0] movable_head_data_pair_out,
    output logic movable_head_data_pair_oe_out,
    output logic [1:0] fixed_head_data_pair_out,
    output logic fixed_head_data_pair_oe_out,
    // Read side
    output logic read_gate_out,
    output logic read_path_en_out,
    output logic read_data_out,
    output logic read_squelch_gate_out,
    output logic mark_gate_control_out,
    output logic fixed_block_installed_out,
    // Error flags
    output head_ctrl_pkg::err_flags_t err_flags_out
);
    import head_ctrl_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    // Pins from the enclosure and controller arrive asynchronously
    localparam int NSYNC = 12;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic wdata_last_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            // Idle pin levels, so no false write gate follows reset
            sync1_q <= `SYNC_RST;
            sync2_q <= `SYNC_RST;
        end else begin
            sync1_q <= {mfm_write_data_in, write_gate_select_n_in, read_only_flag_in,
                fixed_block_present_n_in, unsafe_fixed_in, unsafe_movable_in,
                delta_active_in, supply_overload_in, wsel_overcurrent_in,
                write_current_sense_in, movable_head_data_pair_in, fixed_head_data_pair_in};
            sync2_q <= sync1_q;
        end
    end
    logic wdata_s, wgate_n_s, read_only_flag_s, fb_n_s, usfx_s, usmv_s;
    logic delta_s, overload_s, wsel_oc_s, wcur_s, rdmv_s, rdfx_s;
    assign {wdata_s, wgate_n_s, read_only_flag_s, fb_n_s, usfx_s, usmv_s,
        delta_s, overload_s, wsel_oc_s, wcur_s, rdmv_s, rdfx_s} = sync2_q;

    // ****************************************
    // Head decoding
    // ****************************************
    function automatic logic [`FX_CHIPS-1:0] fixed_decode(input logic [2:0] up,
                                                          input logic [1:0] range);
        logic [3:0] idx;
        // Range bit 1 picks the upper decoder; its last code has no chip
        idx = {range[1], ~up};
        fixed_decode = {`FX_CHIPS{1'b1}};
        if (range != 2'h0 && idx != 4'hF) begin
            fixed_decode[idx] = 1'b0;
        end
    endfunction

    logic [2:0] upper;
    logic fixed_mode;
    assign upper = head_sel_in.head_address_bits[4:2];
    assign fixed_mode = head_sel_in.fixed_mode;

    logic [`MV_CHIPS-1:0] mv_sel_n_d;
    always_comb begin
        mv_sel_n_d = {`MV_CHIPS{1'b1}};
        if (!fixed_mode && upper < 3'h5) begin
            mv_sel_n_d[upper] = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            movable_chip_select_n_out <= {`MV_CHIPS{1'b1}};
            fixed_chip_select_n_out <= {`FX_CHIPS{1'b1}};
            head_core_select_out <= 2'h0;
            fixed_head_range_lines_out <= 3'h0;
            fixed_block_installed_out <= 1'b0;
        end else begin
            movable_chip_select_n_out <= mv_sel_n_d;
            fixed_chip_select_n_out <= fixed_mode ?
                fixed_decode(upper, head_sel_in.fixed_head_range_bits) :
                {`FX_CHIPS{1'b1}};
            head_core_select_out <= head_sel_in.head_address_bits[1:0];
            fixed_head_range_lines_out <= ~upper;
            fixed_block_installed_out <= !fb_n_s;
        end
    end

    // ****************************************
    // Write selects and current
    // ****************************************
    // Controller has selected the head before gating the write
    logic writing;
    assign writing = !wgate_n_s;
    logic odd_head;
    assign odd_head = head_sel_in.head_address_bits[0];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            write_select_movable_out <= 1'b0;
            write_select_fixed_out <= 1'b0;
            write_mode_movable_out <= 1'b0;
            write_mode_fixed_out <= 1'b0;
            write_current_en_out <= 1'b0;
            write_current_level_out <= `IW_20MA;
            main_current_select_out <= 1'b0;
            delta_current_gate1_out <= 1'b0;
            delta_current_gate2_out <= 1'b0;
        end else begin
            write_select_movable_out <= writing && !fixed_mode;
            write_select_fixed_out <= writing && fixed_mode;
            write_mode_movable_out <= writing && !fixed_mode;
            write_mode_fixed_out <= writing && fixed_mode;
            write_current_en_out <= writing && !read_only_flag_s;
            if (fixed_mode) begin
                write_current_level_out <= head_sel_in.fixed_head_range_bits[1] ?
                    `IW_45MA : `IW_40MA;
            end else begin
                write_current_level_out <= odd_head ? `IW_20MA : `IW_25MA;
            end
            main_current_select_out <= writing && !read_only_flag_s;
            delta_current_gate1_out <= writing && !read_only_flag_s && (fixed_mode || !odd_head);
            delta_current_gate2_out <= writing && !read_only_flag_s && fixed_mode;
        end
    end

    // ****************************************
    // Write data toggle and data pairs
    // ****************************************
    logic wdata_ff_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wdata_last_q <= 1'b0;
            wdata_ff_q <= 1'b0;
        end else begin
            wdata_last_q <= wdata_s;
            if (wdata_s && !wdata_last_q) begin
                wdata_ff_q <= !wdata_ff_q;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            movable_head_data_pair_out <= 2'h0;
            fixed_head_data_pair_out <= 2'h0;
            movable_head_data_pair_oe_out <= 1'b0;
            fixed_head_data_pair_oe_out <= 1'b0;
            read_data_out <= 1'b0;
        end else begin
            movable_head_data_pair_out <= {wdata_ff_q, !wdata_ff_q};
            fixed_head_data_pair_out <= {wdata_ff_q, !wdata_ff_q};
            movable_head_data_pair_oe_out <= write_select_movable_out;
            fixed_head_data_pair_oe_out <= write_select_fixed_out;
            read_data_out <= read_path_en_out && (fixed_mode ? rdfx_s : rdmv_s);
        end
    end

    // ****************************************
    // Read gating and squelch
    // ****************************************
    wr_state_t state_q;
    logic [`CNT_W-1:0] sq_cnt_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            sq_cnt_q <= '0;
            read_squelch_gate_out <= 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (writing) begin
                        state_q <= ST_WRITE;
                        read_squelch_gate_out <= 1'b0;
                    end
                end
                ST_WRITE: begin
                    if (!writing) begin
                        state_q <= ST_RECOVER;
                        sq_cnt_q <= '0;
                    end
                end
                ST_RECOVER: begin
                    if (writing) begin
                        state_q <= ST_WRITE;
                    end else if (sq_cnt_q == `CNT_W'(`SQUELCH_DELAY_CYC - 1)) begin
                        read_squelch_gate_out <= 1'b1;
                        state_q <= ST_IDLE;
                    end else begin
                        sq_cnt_q <= sq_cnt_q + `CNT_W'(1);
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            read_gate_out <= 1'b0;
            read_path_en_out <= 1'b1;
            mark_gate_control_out <= 1'b0;
        end else begin
            read_gate_out <= read_tag3_in && read_bus1_in;
            read_path_en_out <= !write_mode_movable_out && !write_mode_fixed_out;
            mark_gate_control_out <= variable_sector_in && am_read_cmd_in;
        end
    end

    // ****************************************
    // Error checks
    // ****************************************
    // Transition check waits ~12 byte times so the write settles first
    logic [`CNT_W-1:0] xchk_cnt_q;
    logic wgate_last_q;
    logic gate_rise;
    assign gate_rise = writing && wgate_last_q;
    err_flags_t err_q;
    logic [1:0] delta_on_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wgate_last_q <= 1'b1;
            xchk_cnt_q <= '0;
            delta_on_q <= 2'h0;
            err_q <= `ERR_RST;
        end else begin
            wgate_last_q <= wgate_n_s;
            delta_on_q <= {delta_on_q[0], delta_current_gate1_out};
            if (gate_rise) begin
                xchk_cnt_q <= '0;
            end else if (writing && xchk_cnt_q != `CNT_W'(`XCHK_DELAY_CYC)) begin
                xchk_cnt_q <= xchk_cnt_q + `CNT_W'(1);
            end
            // Sets win over the clear at gate rise
            err_q.multi_head <= (err_q.multi_head && !gate_rise) || overload_s ||
                ($countones(~movable_chip_select_n_out) > 1);
            // Delta sense returns two syncs late; judge it only after two cycles on
            err_q.delta_iw <= (err_q.delta_iw && !gate_rise) ||
                (delta_current_gate1_out && delta_on_q[1] && !delta_s);
            err_q.transition <= (err_q.transition && !gate_rise) ||
                (writing && xchk_cnt_q == `CNT_W'(`XCHK_DELAY_CYC) &&
                 (usfx_s || usmv_s));
            err_q.write_on_read <= (err_q.write_on_read && !gate_rise) ||
                (state_q == ST_IDLE && !writing && wcur_s);
            err_q.head_short <= (err_q.head_short && !gate_rise) ||
                (writing && wsel_oc_s);
        end
    end
    assign err_flags_out = err_q;
endmodule
`default_nettype wire

/* dv/head_ctrl_checker.sv */
// Assertion checker for the head select and write control block
`timescale 1ns/1ps
`default_nettype none
module head_ctrl_checker (
    // Clock, reset and stimulus
    input wire logic clk_in,
    input wire logic rst_in,
    input wire head_ctrl_pkg::head_sel_t head_sel_in,
    input wire logic write_gate_select_n_in,
    input wire logic read_only_flag_in,
    input wire logic read_tag3_in,
    input wire logic read_bus1_in,
    input wire logic am_read_cmd_in,
    input wire logic variable_sector_in,
    input wire logic wsel_overcurrent_in,
    // Observed outputs
    input wire logic [4:0] movable_chip_select_n_out,
    input wire logic [1:0] head_core_select_out,
    input wire logic [2:0] fixed_head_range_lines_out,
    input wire logic write_select_movable_out,
    input wire logic write_mode_movable_out,
    input wire logic write_mode_fixed_out,
    input wire logic write_current_en_out,
    input wire logic movable_head_data_pair_oe_out,
    input wire logic read_gate_out,
    input wire logic read_path_en_out,
    input wire logic read_squelch_gate_out,
    input wire logic mark_gate_control_out,
    input wire head_ctrl_pkg::err_flags_t err_flags_out
);
    import head_ctrl_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    chk_one_movable: assert property ($countones(~movable_chip_select_n_out) <= 1)
        else $error("More than one movable chip selected");
    chk_core_range: assert property (!$past(rst_in) |->
        {fixed_head_range_lines_out, head_core_select_out} ==
        {~$past(head_sel_in.head_address_bits[4:2]), $past(head_sel_in.head_address_bits[1:0])})
        else $error("Head core or range lines do not follow the address");
    chk_ro_no_current: assert property (read_only_flag_in [*5] |-> !write_current_en_out)
        else $error("Write current enabled under read only");
    chk_path_mode: assert property (read_path_en_out ==
        !($past(write_mode_movable_out) || $past(write_mode_fixed_out)))
        else $error("Read path not tied to write modes");
    chk_oe_select: assert property (movable_head_data_pair_oe_out |->
        $past(write_select_movable_out))
        else $error("Movable data pair driven without write select");
    chk_read_gate: assert property (read_tag3_in && read_bus1_in |=> read_gate_out)
        else $error("Read gate missing after read command");
    chk_mark_gate: assert property (am_read_cmd_in && variable_sector_in |=>
        mark_gate_control_out)
        else $error("Mark gate missing after mark read command");
    chk_squelch_hold: assert property ($rose(write_gate_select_n_in) |->
        ##1 !read_squelch_gate_out [*8])
        else $error("Squelch gate rose too early");
    chk_squelch_rise: assert property ($rose(write_gate_select_n_in) |->
        ##[96:110] read_squelch_gate_out)
        else $error("Squelch gate late");
    chk_short_flag: assert property (wsel_overcurrent_in && write_select_movable_out |->
        ##[1:4] err_flags_out.head_short)
        else $error("Head short not flagged");
endmodule
bind disk_head_select_write_ctrl head_ctrl_checker u_chk (.*);
`default_nettype wire

/* dv/head_ic_model.sv */
// Behavioural model of the head ICs and sense lines in the enclosure
`timescale 1ns/1ps
`default_nettype none
module head_ic_model (
    // Drive from the block
    input wire logic clk_in,
    input wire logic [4:0] sel_n_in,
    input wire logic wsel_mv_in,
    input wire logic wsel_fx_in,
    input wire logic iw_en_in,
    input wire logic delta_gate_in,
    input wire logic mv_oe_in,
    input wire logic fx_oe_in,
    // Fault knobs from the bench
    input wire logic stuck_in,
    input wire logic no_delta_in,
    input wire logic short_in,
    input wire logic leak_in,
    input wire logic over_in,
    input wire logic absent_in,
    // Sense lines back to the block
    output logic present_n_out,
    output logic unsafe_mv_out,
    output logic unsafe_fx_out,
    output logic delta_act_out,
    output logic overload_out,
    output logic overcur_out,
    output logic sense_out,
    output logic mv_rd_out,
    output logic fx_rd_out
);
    logic rd_q = 1'b0;
    // Released lines show a changing pattern, never the last written bit
    always_ff @(posedge clk_in) begin
        rd_q <= ~rd_q;
    end
    assign present_n_out = absent_in;
    assign unsafe_mv_out = wsel_mv_in & stuck_in;
    assign unsafe_fx_out = wsel_fx_in & stuck_in;
    assign delta_act_out = delta_gate_in & ~no_delta_in;
    assign overload_out = ($countones(~sel_n_in) > 1) | over_in;
    assign overcur_out = (wsel_mv_in | wsel_fx_in) & short_in;
    assign sense_out = iw_en_in | leak_in;
    assign mv_rd_out = mv_oe_in ? 1'b0 : rd_q;
    assign fx_rd_out = fx_oe_in ? 1'b0 : rd_q;
endmodule
`default_nettype wire

/* dv/test_disk_head_select_write_ctrl.sv */
// Self-checking testbench for the head select and write control block
`timescale 1ns/1ps
`default_nettype none
module test_disk_head_select_write_ctrl;
    import head_ctrl_pkg::*;
    logic clk_in = 1'b0, rst_in = 1'b1, write_gate_select_n_in = 1'b1, read_only_flag_in = 1'b0;
    logic mfm_write_data_in = 1'b0, read_tag3_in = 1'b0, read_bus1_in = 1'b0;
    logic am_read_cmd_in = 1'b0, variable_sector_in = 1'b0;
    logic stuck = 1'b0, no_delta = 1'b0, short = 1'b0, leak = 1'b0, over = 1'b0, r;
    logic absent = 1'b0;
    head_sel_t head_sel_in = '0;
    logic fixed_block_present_n_in, unsafe_fixed_in, unsafe_movable_in, delta_active_in;
    logic supply_overload_in, wsel_overcurrent_in, write_current_sense_in;
    logic movable_head_data_pair_in, fixed_head_data_pair_in;
    logic [4:0] movable_chip_select_n_out;
    logic [14:0] fixed_chip_select_n_out;
    logic [1:0] head_core_select_out, write_current_level_out, prev;
    logic [1:0] movable_head_data_pair_out, fixed_head_data_pair_out;
    logic [2:0] fixed_head_range_lines_out;
    logic write_select_movable_out, write_select_fixed_out, write_mode_movable_out;
    logic write_mode_fixed_out, write_current_en_out, main_current_select_out;
    logic delta_current_gate1_out, delta_current_gate2_out, movable_head_data_pair_oe_out;
    logic fixed_head_data_pair_oe_out, read_gate_out, read_path_en_out, read_data_out;
    logic read_squelch_gate_out, mark_gate_control_out, fixed_block_installed_out;
    err_flags_t err_flags_out;
    int fail_count = 0, checks = 0, cyc = 0;
    disk_head_select_write_ctrl DUT (.*);
    head_ic_model model (.clk_in, .sel_n_in(movable_chip_select_n_out),
        .wsel_mv_in(write_select_movable_out), .wsel_fx_in(write_select_fixed_out),
        .iw_en_in(write_current_en_out), .delta_gate_in(delta_current_gate1_out),
        .mv_oe_in(movable_head_data_pair_oe_out), .fx_oe_in(fixed_head_data_pair_oe_out),
        .stuck_in(stuck), .no_delta_in(no_delta), .short_in(short), .leak_in(leak),
        .over_in(over), .absent_in(absent), .present_n_out(fixed_block_present_n_in),
        .unsafe_mv_out(unsafe_movable_in), .unsafe_fx_out(unsafe_fixed_in),
        .delta_act_out(delta_active_in), .overload_out(supply_overload_in),
        .overcur_out(wsel_overcurrent_in), .sense_out(write_current_sense_in),
        .mv_rd_out(movable_head_data_pair_in), .fx_rd_out(fixed_head_data_pair_in));
    always #10 clk_in = ~clk_in;
    // Whole run is under 1500 cycles
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    // Covers the two sync stages plus the output register
    task automatic gate(input logic v);
        write_gate_select_n_in = v;
        tick(8);
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        tick(3);
        cmp({movable_chip_select_n_out, read_path_en_out, read_squelch_gate_out},
            16'h7F);
        cmp(err_flags_out, 16'h0);
        rst_in = 1'b0;
        for (int a = 0; a < 32; a++) begin
            head_sel_in.head_address_bits = 5'(a);
            tick(2);
            cmp(movable_chip_select_n_out,
                (a < 20) ? ~(16'h1 << (a / 4)) & 16'h1F : 16'h1F);
            cmp({fixed_head_range_lines_out, head_core_select_out},
                {~3'(a / 4), 2'(a)});
        end
        // Low range reaches chips 0 to 7, high range 8 to 14
        for (int f = 0; f < 24; f++) begin
            head_sel_in = {1'b1, 2'(f / 8), 3'(f), 2'h1};
            tick(2);
            cmp(fixed_chip_select_n_out, (f < 8 || f == 16) ? 16'h7FFF :
                ~(16'h1 << ((f < 16) ? 7 - f % 8 : 15 - f % 8)) & 16'h7FFF);
            cmp(movable_chip_select_n_out, 16'h1F);
        end
        head_sel_in = 8'h08;
        gate(1'b0);
        cmp({write_select_movable_out, write_mode_movable_out, write_select_fixed_out,
            write_current_en_out}, 16'hD);
        cmp(write_current_level_out, 16'h1);
        cmp({main_current_select_out, delta_current_gate1_out, read_path_en_out,
            read_squelch_gate_out}, 16'hC);
        prev = movable_head_data_pair_out;
        mfm_write_data_in = 1'b1;
        tick(3);
        mfm_write_data_in = 1'b0;
        tick(3);
        cmp({movable_head_data_pair_oe_out, movable_head_data_pair_out,
            fixed_head_data_pair_out}, {1'b1, ~prev, ~prev});
        cmp({fixed_head_data_pair_oe_out, err_flags_out}, 16'h0);
        gate(1'b1);
        cmp({read_path_en_out, read_squelch_gate_out}, 16'h2);
        tick(100);
        cmp(read_squelch_gate_out, 16'h1);
        for (int k = 0; k < 3; k++) begin
            head_sel_in = {k != 0, 2'(k), (k == 0) ? 5'h09 : 5'h00};
            read_only_flag_in = (k == 0);
            gate(1'b0);
            cmp(write_current_level_out, (k == 0) ? 16'h0 : 16'(k + 1));
            cmp({write_current_en_out, write_select_fixed_out, write_mode_fixed_out,
                fixed_head_data_pair_oe_out, delta_current_gate2_out},
                (k == 0) ? 16'h0 : 16'h1F);
            cmp(movable_chip_select_n_out, (k == 0) ? 16'h1B : 16'h1F);
            gate(1'b1);
            // Let the squelch rise before the next write starts
            tick(110);
        end
        head_sel_in = 8'h08;
        {no_delta, short, over, stuck} = 4'hF;
        gate(1'b0);
        cmp(err_flags_out, 16'h13);
        tick(490);
        cmp(err_flags_out.transition, 16'h1);
        {no_delta, short, over, stuck} = 4'h0;
        gate(1'b1);
        // Current seen during recovery is not yet an error
        tick(110);
        leak = 1'b1;
        tick(5);
        cmp(err_flags_out, 16'h1F);
        leak = 1'b0;
        gate(1'b0);
        cmp(err_flags_out, 16'h0);
        gate(1'b1);
        {read_tag3_in, read_bus1_in, am_read_cmd_in, variable_sector_in} = 4'hF;
        tick(2);
        cmp({read_gate_out, mark_gate_control_out, fixed_block_installed_out}, 16'h7);
        {read_tag3_in, read_bus1_in, am_read_cmd_in, variable_sector_in} = 4'hA;
        absent = 1'b1;
        tick(3);
        cmp({read_gate_out, mark_gate_control_out}, 16'h0);
        cmp(fixed_block_installed_out, 16'h0);
        r = read_data_out;
        tick(1);
        cmp(read_data_out, {15'h0000, ~r});
        tally_and_finish();
    end
endmodule
`default_nettype wire
